// file: inc/ddr2_bank_power_map.svh
// Widths, reset values and timing counts for the bank-close, refresh and power-down logic.
`ifndef DDR2_BANK_POWER_MAP_SVH
`define DDR2_BANK_POWER_MAP_SVH

`define CLK_PERIOD_PS           4000
`define BANK_COUNT              8
`define TIMER_WIDTH             5

// Analogue times in picoseconds.
`define T_RTP_PS                7500
`define T_RFC_PS                127500
`define T_REFI_PS               7800000

// Least times round up; the average refresh interval is a longest time and rounds down.
`define READ_TO_CLOSE_CYCLES    ((`T_RTP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define REFRESH_CYCLES          ((`T_RFC_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define REFI_CYCLES             (`T_REFI_PS / `CLK_PERIOD_PS)

`define REFRESH_ROW_WIDTH       13
`define REFRESH_ROW_RESET       13'h0000
`define REFRESH_TIMER_WIDTH     12
`define REFRESH_TIMER_WIDTH_RST 12'h000

`endif

// file: inc/ddr2_bank_power_pkg.sv
// Types for the bank-close, refresh and power-down logic.
package ddr2_bank_power_pkg;

    typedef enum logic [1:0]
    {
        DEV_RUN,
        DEV_POWER_DOWN,
        DEV_SELF_REFRESH
    } dev_state_t;

    typedef enum logic [1:0]
    {
        PD_NONE,
        PD_PRECHARGE,
        PD_FAST_ACTIVE,
        PD_SLOW_ACTIVE
    } pd_kind_t;

endpackage : ddr2_bank_power_pkg

// file: verif/ddr2_bank_power_props.sv
// Concurrent checks on the ports of the bank, refresh and power-down block.
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_bank_power_map.svh"
module ddr2_bank_power_props
(
    input wire logic                          MCLK,
    input wire logic                          RST,
    input wire logic                          CKE,
    input wire logic                          CS_N,
    input wire logic                          RAS_N,
    input wire logic                          CAS_N,
    input wire logic                          WE_N,
    input wire logic                          A10,
    input wire logic [2:0]                    BA,
    input wire logic                          SLOW_EXIT,
    input wire logic [2:0]                    WRITE_LATENCY,
    input wire logic                          BURST_EIGHT,
    input wire logic [2:0]                    WRITE_RECOVERY,
    input wire logic [`BANK_COUNT-1:0]        BANK_OPEN,
    input wire logic                          REFRESH_BUSY,
    input wire logic [`REFRESH_ROW_WIDTH-1:0] REFRESH_ROW,
    input wire logic                          SELF_REFRESH,
    input wire logic                          POWER_DOWN,
    input wire logic [1:0]                    POWER_DOWN_KIND,
    input wire logic                          DLL_ON,
    input wire logic                          INPUT_BUFFERS_ON,
    input wire logic                          BURST_BUSY
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    logic       cke_q;
    logic [5:0] cnt_q;
    logic [5:0] lim_q;
    logic [2:0] bk_q;
    wire        nop = CS_N || (RAS_N && CAS_N && WE_N);
    wire        run = cke_q && !SELF_REFRESH && !POWER_DOWN;
    wire        go  = run && CKE && !CS_N;
    wire [2:0]  cmd = {RAS_N, CAS_N, WE_N};
    wire        wap = go && cmd == 3'h4 && A10;
    always_ff @(posedge MCLK)
    begin
        cke_q <= RST ? 1'b0 : CKE;
    end
    // Counts edges since the last write with auto-close.
    always_ff @(posedge MCLK)
    begin
        if (RST)
            cnt_q <= 6'h00;
        else if (wap)
            cnt_q <= 6'h01;
        else if (cnt_q != 6'h00 && cnt_q <= lim_q + 6'h02)
            cnt_q <= cnt_q + 6'h01;
        else
            cnt_q <= 6'h00;
    end
    always_ff @(posedge MCLK)
    begin
        if (wap)
        begin
            bk_q  <= BA;
            lim_q <= {3'h0, WRITE_LATENCY} + (BURST_EIGHT ? 6'h04 : 6'h02) + {3'h0, WRITE_RECOVERY};
        end
    end
    property p_close;
        go && cmd == 3'h2 |=> ($past(A10) ? BANK_OPEN == 8'h00 : !BANK_OPEN[$past(BA)]);
    endproperty
    a_close: assert property (p_close) else $error("precharge left a bank open");
    property p_ref;
        go && cmd == 3'h1 |=> REFRESH_BUSY && REFRESH_ROW == $past(REFRESH_ROW) + 13'h0001;
    endproperty
    a_ref: assert property (p_ref) else $error("refresh not started");
    property p_span;
        $rose(REFRESH_BUSY) |-> BANK_OPEN == 8'h00 ##31 REFRESH_BUSY ##1 !REFRESH_BUSY;
    endproperty
    a_span: assert property (p_span) else $error("refresh span wrong");
    property p_sr_in;
        run && !CKE && !CS_N && cmd == 3'h1 ##1 !CKE |-> ##1 SELF_REFRESH && !DLL_ON && REFRESH_BUSY;
    endproperty
    a_sr_in: assert property (p_sr_in) else $error("self-refresh entry wrong");
    property p_sr_out;
        SELF_REFRESH && !cke_q && CKE |-> ##2 !SELF_REFRESH ##[0:2] DLL_ON;
    endproperty
    a_sr_out: assert property (p_sr_out) else $error("self-refresh exit wrong");
    property p_pd_in;
        run && !CKE && nop && !BURST_BUSY ##1 !CKE |-> ##1 POWER_DOWN && !INPUT_BUFFERS_ON
            && POWER_DOWN_KIND == ($past(BANK_OPEN, 2) == 8'h00 ? 2'h1 : $past(SLOW_EXIT, 2) ? 2'h3 : 2'h2);
    endproperty
    a_pd_in: assert property (p_pd_in) else $error("power-down entry wrong");
    property p_pd_out;
        POWER_DOWN && !cke_q && CKE && nop |-> ##2 !POWER_DOWN && INPUT_BUFFERS_ON;
    endproperty
    a_pd_out: assert property (p_pd_out) else $error("power-down exit wrong");
    property p_ac_open;
        cnt_q != 6'h00 && cnt_q == lim_q |-> BANK_OPEN[bk_q];
    endproperty
    a_ac_open: assert property (p_ac_open) else $error("bank closed early");
    property p_ac_shut;
        cnt_q != 6'h00 && cnt_q == lim_q + 6'h02 |-> !BANK_OPEN[bk_q];
    endproperty
    a_ac_shut: assert property (p_ac_shut) else $error("bank not auto-closed");
    property p_nop_keep;
        go && cmd == 3'h4 ##1 nop |-> BURST_BUSY;
    endproperty
    a_nop_keep: assert property (p_nop_keep) else $error("burst ended by no-operation");
    c_ac: cover property (cnt_q != 6'h00 && cnt_q == lim_q + 6'h02);
    c_sr: cover property ($rose(SELF_REFRESH));
    c_pd: cover property ($rose(POWER_DOWN));
endmodule : ddr2_bank_power_props
bind ddr2_bank_power ddr2_bank_power_props chk_u
(
    .MCLK(MCLK), .RST(RST), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N),
    .A10(A10), .BA(BA), .SLOW_EXIT(SLOW_EXIT), .WRITE_LATENCY(WRITE_LATENCY), .BURST_EIGHT(BURST_EIGHT),
    .WRITE_RECOVERY(WRITE_RECOVERY), .BANK_OPEN(BANK_OPEN), .REFRESH_BUSY(REFRESH_BUSY),
    .REFRESH_ROW(REFRESH_ROW), .SELF_REFRESH(SELF_REFRESH), .POWER_DOWN(POWER_DOWN),
    .POWER_DOWN_KIND(POWER_DOWN_KIND), .DLL_ON(DLL_ON), .INPUT_BUFFERS_ON(INPUT_BUFFERS_ON),
    .BURST_BUSY(BURST_BUSY)
);
`default_nettype wire

// file: verif/ddr2_ctrl_model.sv
// Command bus and clock enable driver standing in for the memory controller.
`timescale 1ns/100ps
`default_nettype none
module ddr2_ctrl_model
(
    input  wire logic       clk,
    output var  logic       cke,
    output var  logic       cs_n,
    output var  logic       ras_n,
    output var  logic       cas_n,
    output var  logic       we_n,
    output var  logic       a10,
    output var  logic [2:0] ba
);
    initial {cke, cs_n, ras_n, cas_n, we_n, a10, ba} = 9'h0f0;
    // One command for one edge, then no-operations until the spacing has run out.
    task automatic send(input logic cke_v, input logic [3:0] code, input logic [2:0] bank,
                        input logic a10_v, input int gap);
        @(posedge clk);
        cke <= cke_v;
        {cs_n, ras_n, cas_n, we_n} <= code;
        ba <= bank;
        a10 <= a10_v;
        repeat (gap - 1)
        begin
            @(posedge clk);
            {cs_n, ras_n, cas_n, we_n} <= 4'h7;
            ba <= ~ba;
            a10 <= ~a10;
        end
        #1;
    endtask : send
endmodule : ddr2_ctrl_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the bank, refresh and power-down block.
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_bank_power_map.svh"
module tb_top;
    localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, WR = 4'h4, PRE = 4'h2, REF = 4'h1, RD = 4'h5;
    logic                          MCLK = 1'b0;
    logic                          RST = 1'b1;
    logic                          clk_run = 1'b1;
    logic                          slow = 1'b0;
    logic                          b8 = 1'b0;
    logic [2:0]                    al = 3'h0;
    logic                          cke, cs_n, ras_n, cas_n, we_n, a10;
    logic [2:0]                    ba;
    logic [`BANK_COUNT-1:0]        open;
    logic                          rbusy, sr, pd, dll, ibuf, bb, lost;
    logic [1:0]                    kind;
    logic [`REFRESH_ROW_WIDTH-1:0] row;
    logic [`REFRESH_ROW_WIDTH-1:0] exp_row = 13'h0000;
    int                            miscompares = 0;
    int                            n_compared = 0;
    int                            t;
    always #2 MCLK = clk_run ? ~MCLK : MCLK;
    ddr2_ctrl_model ctrl_u (.clk(MCLK), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
                            .we_n(we_n), .a10(a10), .ba(ba));
    ddr2_bank_power dut_u
    (
        .MCLK(MCLK), .RST(RST), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
        .A10(a10), .BA(ba), .SLOW_EXIT(slow), .ADDITIVE_LATENCY(al), .WRITE_LATENCY(3'h3),
        .BURST_EIGHT(b8), .WRITE_RECOVERY(3'h3), .BANK_OPEN(open), .REFRESH_BUSY(rbusy),
        .REFRESH_ROW(row), .SELF_REFRESH(sr), .POWER_DOWN(pd), .POWER_DOWN_KIND(kind),
        .DLL_ON(dll), .INPUT_BUFFERS_ON(ibuf), .BURST_BUSY(bb), .CONTENTS_LOST(lost)
    );
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    // Reset, then clock enable high for two edges before the first command.
    task automatic rst();
        @(posedge MCLK);
        RST <= 1'b1;
        repeat (12) @(posedge MCLK);
        RST <= 1'b0;
        ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 2);
    endtask : rst
    initial
    begin
        #20000;
        miscompares++;
        conclude();
    end
    initial
    begin
        rst();
        chk("reset", 16'({lost, ibuf, dll, pd, sr, kind, open}), 16'h3000);
        chk("reset row", 16'(row), 16'h0000);
        for (int b = 0; b < 8; b++)
            ctrl_u.send(1'b1, ACT, 3'(b), 1'b0, 1);
        ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 2);
        chk("open all", 16'(open), 16'h00ff);
        ctrl_u.send(1'b1, PRE, 3'h3, 1'b0, 2);
        chk("pre one", 16'(open), 16'h00f7);
        ctrl_u.send(1'b1, PRE, 3'h5, 1'b0, 1);
        ctrl_u.send(1'b1, PRE, 3'h0, 1'b1, 2);
        chk("pre all", 16'(open), 16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge MCLK);
            b8 <= k[0];
            t = 3 + 3 + (k ? 4 : 2);
            ctrl_u.send(1'b1, ACT, 3'h2, 1'b0, 2);
            ctrl_u.send(1'b1, WR, 3'h2, 1'b1, 3);
            chk("burst", 16'(bb), 16'h0001);
            ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, t - 3);
            chk("ac open", 16'(open[2]), 16'h0001);
            ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 3);
            chk("ac shut", 16'(open[2]), 16'h0000);
            ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 6);
        end
        // Read with auto-close at AL 2 and BL8 closes AL+BL/2+max(read_to_close_cycles,2)-2 = 6 clocks on.
        @(posedge MCLK);
        al <= 3'h2;
        ctrl_u.send(1'b1, ACT, 3'h4, 1'b0, 2);
        ctrl_u.send(1'b1, RD, 3'h4, 1'b1, 2);
        chk("rd busy", 16'(bb), 16'h0001);
        ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 5);
        chk("rd open", 16'(open[4]), 16'h0001);
        ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 2);
        chk("rd shut", 16'(open[4]), 16'h0000);
        ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 4);
        ctrl_u.send(1'b1, REF, 3'h5, 1'b1, 2);
        exp_row++;
        chk("ref", 16'({rbusy, open}), 16'h0100);
        chk("ref row", 16'(row), 16'(exp_row));
        ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, `REFRESH_CYCLES + 1);
        chk("ref done", 16'(rbusy), 16'h0000);
        for (int k = 1; k < 4; k++)
        begin
            @(posedge MCLK);
            slow <= (k == 3);
            if (k > 1)
                ctrl_u.send(1'b1, ACT, 3'h1, 1'b0, 1);
            ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 2);
            ctrl_u.send(1'b0, NOP, 3'h0, 1'b0, 4);
            chk("pd", 16'({pd, ibuf, kind}), 16'({1'b1, 1'b0, 2'(k)}));
            chk("pd dll", 16'(dll), 16'(k == 2));
            ctrl_u.send(1'b0, ACT, 3'h6, 1'b0, 2);
            ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 4);
            chk("pd exit", 16'({pd, ibuf, open}), 16'({2'b01, k > 1 ? 8'h02 : 8'h00}));
            ctrl_u.send(1'b1, PRE, 3'h0, 1'b1, 4);
        end
        ctrl_u.send(1'b0, REF, 3'h0, 1'b0, 4);
        exp_row++;
        chk("sr", 16'({lost, sr, dll, ibuf}), 16'h0004);
        chk("sr row", 16'(row), 16'(exp_row));
        ctrl_u.send(1'b0, ACT, 3'h0, 1'b0, 2);
        chk("sr act", 16'(open), 16'h0000);
        clk_run = 1'b0;
        #100;
        clk_run = 1'b1;
        ctrl_u.send(1'b0, NOP, 3'h0, 1'b0, 8);
        ctrl_u.send(1'b1, NOP, 3'h0, 1'b0, 40);
        chk("sr exit", 16'({sr, dll}), 16'h0001);
        ctrl_u.send(1'b1, REF, 3'h0, 1'b0, 34);
        exp_row++;
        chk("sr ref", 16'(row), 16'(exp_row));
        ctrl_u.send(1'b1, ACT, 3'h0, 1'b0, 2);
        ctrl_u.send(1'b1, WR, 3'h0, 1'b0, 2);
        ctrl_u.send(1'b0, NOP, 3'h0, 1'b0, 3);
        chk("lost", 16'({lost, pd}), 16'h0002);
        rst();
        chk("reinit", 16'({lost, open}), 16'h0000);
        conclude();
    end
endmodule : tb_top
`default_nettype wire

// file: verilog/bank_autoclose.sv
// Per-bank countdown that closes a bank once its auto-close delay has run out.
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_bank_power_map.svh"

module bank_autoclose
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [`BANK_COUNT-1:0]     load,
    input  wire logic [`TIMER_WIDTH-1:0]    load_value,
    output logic      [`BANK_COUNT-1:0]     close
);

    genvar b;
    generate
        for (b = 0; b < `BANK_COUNT; b = b + 1)
        begin : g_bank
            logic [`TIMER_WIDTH-1:0] count_q;
            logic                    armed_q;

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    count_q <= '0;
                    armed_q <= 1'b0;
                end
                else if (load[b])
                begin
                    count_q <= load_value;
                    armed_q <= 1'b1;
                end
                else if (armed_q && count_q != '0)
                begin
                    count_q <= count_q - 1'b1;
                end
                else
                begin
                    armed_q <= 1'b0;
                end
            end

            assign close[b] = armed_q && (count_q == '0);
        end
    endgenerate

endmodule : bank_autoclose

`default_nettype wire

// file: verilog/ddr2_bank_power.sv
// Bank closing, refresh, self-refresh and power-down state of a DDR2 memory die.
//
// Notes on behaviour
// - Write with A10 high closes the bank after burst plus write recovery.
// - Chip select, row and column strobe low, write enable high means refresh.
// - Refresh uses the internal row counter and leaves every bank closed.
// - Refresh encoding with clock enable low enters self-refresh; held by low enable.
// - Self-refresh turns DLL off, back on at exit, ignores all but enable.
// - One internal refresh soon after self-refresh entry; stay in it minimum time.
// - Enable low with no-operation enters power-down; no burst or recovery running.
// - Idle banks give precharge power-down; otherwise active, A12 picks fast or slow.
// - Power-down turns input buffers off; controller leaves within nine intervals.
// - Enable high with no-operation ends power-down; controller waits exit latency.
// - Chip select, row strobe, write enable low, column strobe high means precharge.
// - Chip select low with all strobes high is a no-operation keeping bursts.
`timescale 1ns/100ps
`default_nettype none
`include "ddr2_bank_power_map.svh"

module ddr2_bank_power
(
    input  wire logic                            MCLK,
    input  wire logic                            RST,
    input  wire logic                            CKE,
    input  wire logic                            CS_N,
    input  wire logic                            RAS_N,
    input  wire logic                            CAS_N,
    input  wire logic                            WE_N,
    input  wire logic                            A10,
    input  wire logic [2:0]                      BA,
    input  wire logic                            SLOW_EXIT,
    input  wire logic [2:0]                      ADDITIVE_LATENCY,
    input  wire logic [2:0]                      WRITE_LATENCY,
    input  wire logic                            BURST_EIGHT,
    input  wire logic [2:0]                      WRITE_RECOVERY,
    output logic      [`BANK_COUNT-1:0]          BANK_OPEN,
    output logic                                 REFRESH_BUSY,
    output logic      [`REFRESH_ROW_WIDTH-1:0]   REFRESH_ROW,
    output logic                                 SELF_REFRESH,
    output logic                                 POWER_DOWN,
    output logic      [1:0]                      POWER_DOWN_KIND,
    output logic                                 DLL_ON,
    output logic                                 INPUT_BUFFERS_ON,
    output logic                                 BURST_BUSY,
    output logic                                 CONTENTS_LOST
);

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    ddr2_bank_power_pkg::dev_state_t state_q;
    logic                            cke_q;
    logic                            sel;
    logic                            cmd_nop;
    logic                            cmd_act;
    logic                            cmd_read;
    logic                            cmd_write;
    logic                            cmd_pre;
    logic                            cmd_ref;
    logic                            running;
    logic [`BANK_COUNT-1:0]          bank_hit;

    // Commands count only in normal running state with enable high on both edges.
    assign running   = (state_q == ddr2_bank_power_pkg::DEV_RUN) && cke_q && CKE;
    assign sel       = !CS_N;
    assign cmd_nop   = CS_N || (RAS_N && CAS_N && WE_N);
    assign cmd_act   = running && sel && !RAS_N && CAS_N && WE_N;
    assign cmd_read  = running && sel && RAS_N && !CAS_N && WE_N;
    assign cmd_write = running && sel && RAS_N && !CAS_N && !WE_N;
    assign cmd_pre   = running && sel && !RAS_N && CAS_N && !WE_N;
    assign cmd_ref   = running && sel && !RAS_N && !CAS_N && WE_N;
    assign bank_hit  = `BANK_COUNT'(1) << BA;

    // ------------------------------------------------------------------
    // Auto-close timing
    // ------------------------------------------------------------------
    logic [`TIMER_WIDTH-1:0] half_burst;
    logic [`TIMER_WIDTH-1:0] rtp_term;
    logic [`TIMER_WIDTH-1:0] read_close;
    logic [`TIMER_WIDTH-1:0] write_close;
    logic [`TIMER_WIDTH-1:0] close_value;
    logic [`BANK_COUNT-1:0]  close_load;
    logic [`BANK_COUNT-1:0]  close_now;

    assign half_burst  = BURST_EIGHT ? `TIMER_WIDTH'(4) : `TIMER_WIDTH'(2);
    assign rtp_term    = (`READ_TO_CLOSE_CYCLES > 2) ? `TIMER_WIDTH'(`READ_TO_CLOSE_CYCLES) : `TIMER_WIDTH'(2);
    assign read_close  = `TIMER_WIDTH'(ADDITIVE_LATENCY) + half_burst + rtp_term - `TIMER_WIDTH'(2);
    assign write_close = `TIMER_WIDTH'(WRITE_LATENCY) + half_burst + `TIMER_WIDTH'(WRITE_RECOVERY);
    assign close_value = cmd_write ? write_close : read_close;
    assign close_load  = ((cmd_read || cmd_write) && A10) ? bank_hit : '0;

    bank_autoclose u_autoclose
    (
        .clk        (MCLK),
        .rst        (RST),
        .load       (close_load),
        .load_value (close_value),
        .close      (close_now)
    );

    // ------------------------------------------------------------------
    // Bank open state
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (RST)
            BANK_OPEN <= '0;
        else if (cmd_ref)
            BANK_OPEN <= '0;
        else if (cmd_pre)
            BANK_OPEN <= A10 ? '0 : (BANK_OPEN & ~bank_hit & ~close_now);
        else
            BANK_OPEN <= (BANK_OPEN & ~close_now) | (cmd_act ? bank_hit : '0);
    end

    // ------------------------------------------------------------------
    // Burst and write recovery tracking
    // ------------------------------------------------------------------
    logic [`TIMER_WIDTH-1:0] burst_q;

    // A no-operation leaves the countdown running; only new bursts reload it.
    always_ff @(posedge MCLK)
    begin
        if (RST)
            burst_q <= '0;
        else if (cmd_write)
            burst_q <= write_close;
        else if (cmd_read)
            burst_q <= `TIMER_WIDTH'(ADDITIVE_LATENCY) + half_burst;
        else if (burst_q != '0)
            burst_q <= burst_q - 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            BURST_BUSY <= 1'b0;
        else
            BURST_BUSY <= cmd_read || cmd_write || (burst_q > `TIMER_WIDTH'(1));
    end

    // ------------------------------------------------------------------
    // Refresh engine
    // ------------------------------------------------------------------
    logic [`REFRESH_TIMER_WIDTH-1:0] rfc_q;
    logic [`REFRESH_TIMER_WIDTH-1:0] refi_q;
    logic                            internal_ref;
    logic                            start_ref;

    // Self-refresh fires one refresh on entry, then one each average interval.
    assign internal_ref = (state_q == ddr2_bank_power_pkg::DEV_SELF_REFRESH) && (refi_q == '0);
    assign start_ref    = cmd_ref || internal_ref;

    always_ff @(posedge MCLK)
    begin
        if (RST)
            refi_q <= `REFRESH_TIMER_WIDTH_RST;
        else if (state_q != ddr2_bank_power_pkg::DEV_SELF_REFRESH)
            refi_q <= `REFRESH_TIMER_WIDTH_RST;
        else if (refi_q == '0)
            refi_q <= `REFRESH_TIMER_WIDTH'(`REFI_CYCLES - 1);
        else
            refi_q <= refi_q - 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            rfc_q <= `REFRESH_TIMER_WIDTH_RST;
        else if (start_ref)
            rfc_q <= `REFRESH_TIMER_WIDTH'(`REFRESH_CYCLES);
        else if (rfc_q != '0)
            rfc_q <= rfc_q - 1'b1;
    end

    // The row comes from the internal counter; the address pins are not looked at.
    always_ff @(posedge MCLK)
    begin
        if (RST)
            REFRESH_ROW <= `REFRESH_ROW_RESET;
        else if (start_ref)
            REFRESH_ROW <= REFRESH_ROW + 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            REFRESH_BUSY <= 1'b0;
        else
            REFRESH_BUSY <= start_ref || (rfc_q > `REFRESH_TIMER_WIDTH'(1));
    end

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (RST)
            cke_q <= 1'b0;
        else
            cke_q <= CKE;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            state_q         <= ddr2_bank_power_pkg::DEV_RUN;
            POWER_DOWN_KIND <= ddr2_bank_power_pkg::PD_NONE;
        end
        else
        begin
            unique case (state_q)
                ddr2_bank_power_pkg::DEV_RUN:
                begin
                    if (cke_q && !CKE && sel && !RAS_N && !CAS_N && WE_N)
                    begin
                        state_q <= ddr2_bank_power_pkg::DEV_SELF_REFRESH;
                    end
                    else if (cke_q && !CKE && cmd_nop && !BURST_BUSY)
                    begin
                        state_q <= ddr2_bank_power_pkg::DEV_POWER_DOWN;
                        if (BANK_OPEN == '0)
                            POWER_DOWN_KIND <= ddr2_bank_power_pkg::PD_PRECHARGE;
                        else if (SLOW_EXIT)
                            POWER_DOWN_KIND <= ddr2_bank_power_pkg::PD_SLOW_ACTIVE;
                        else
                            POWER_DOWN_KIND <= ddr2_bank_power_pkg::PD_FAST_ACTIVE;
                    end
                end
                ddr2_bank_power_pkg::DEV_POWER_DOWN:
                begin
                    if (CKE && cmd_nop)
                    begin
                        state_q         <= ddr2_bank_power_pkg::DEV_RUN;
                        POWER_DOWN_KIND <= ddr2_bank_power_pkg::PD_NONE;
                    end
                end
                ddr2_bank_power_pkg::DEV_SELF_REFRESH:
                begin
                    if (CKE)
                        state_q <= ddr2_bank_power_pkg::DEV_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            SELF_REFRESH     <= 1'b0;
            POWER_DOWN       <= 1'b0;
            DLL_ON           <= 1'b1;
            INPUT_BUFFERS_ON <= 1'b1;
        end
        else
        begin
            SELF_REFRESH     <= (state_q == ddr2_bank_power_pkg::DEV_SELF_REFRESH);
            POWER_DOWN       <= (state_q == ddr2_bank_power_pkg::DEV_POWER_DOWN);
            DLL_ON           <= (state_q == ddr2_bank_power_pkg::DEV_RUN)
                             || (state_q == ddr2_bank_power_pkg::DEV_POWER_DOWN
                                 && POWER_DOWN_KIND == ddr2_bank_power_pkg::PD_FAST_ACTIVE);
            INPUT_BUFFERS_ON <= (state_q == ddr2_bank_power_pkg::DEV_RUN);
        end
    end

    // Enable falling during a burst or recovery, or with any command but a no-operation or self-refresh entry, loses the array.
    always_ff @(posedge MCLK)
    begin
        if (RST)
            CONTENTS_LOST <= 1'b0;
        else if (state_q == ddr2_bank_power_pkg::DEV_RUN && cke_q && !CKE
                 && (BURST_BUSY || !(cmd_nop || (!RAS_N && !CAS_N && WE_N))))
            CONTENTS_LOST <= 1'b1;
    end

endmodule : ddr2_bank_power

`default_nettype wire
